// >>> eccp_pkg.sv
// Purpose: Shared constants for the enhanced unit mode control block.
// Assumes: AXI4-Lite register access, 32-bit data, one word per register.
// Notes:   Notes on behaviour are listed below.
//
// Notes on behaviour
// - Mode zero disables and resets; 0001 reserved.
// - Capture falling, rising, fourth or sixteenth rising.
// - Mode 0010 toggles pin on match.
// - Mode 1000 starts low, sets on match.
// - Mode 1001 starts high, clears on match.
// - Mode 1010 flags only, pin to port.
// - Mode 1011 resets timer, may start conversion.
// - Third unit treats 1011 as 1010.
// - Modes 11xx are PWM with polarity bits.
// - Non-PWM ignores steering; only A used.
// - Steering 00 modulates A only.
// - Steering 01 modulates D, A active.
// - Steering 10 modulates A and B.
// - Steering 11 modulates B, C active.
// - Duty low bits extend high byte to ten.
// - Active external bus overrides B and C.
// - Twelve-bit bus keeps B and C available.
// - Pin select clear moves B, C to alternate.
// - Unit two A pin chosen by select bit.
// - Quad mode D takes plain unit pin.
// - Duty copied to shadow at period match.
package eccp_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0]  ADDR_CONTROL    = 4'h0;
  localparam logic [3:0]  ADDR_DUTY_HIGH  = 4'h4;
  localparam logic [3:0]  ADDR_STATUS     = 4'h8;
  localparam logic [3:0]  ADDR_CONFIG     = 4'hc;
  localparam logic [7:0]  CONTROL_RESET   = 8'h00;
  localparam logic [4:0]  CONFIG_RESET    = 5'h03;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // ****************************************************************
  // Control fields
  // ****************************************************************
  localparam int STEER_MSB = 7;
  localparam int STEER_LSB = 6;
  localparam int DUTY_MSB  = 5;
  localparam int DUTY_LSB  = 4;
  localparam int MODE_MSB  = 3;
  localparam int MODE_LSB  = 0;

  localparam logic [3:0] MODE_OFF       = 4'h0;
  localparam logic [3:0] MODE_RESERVED  = 4'h1;
  localparam logic [3:0] MODE_CMP_TOG   = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL  = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE  = 4'h5;
  localparam logic [3:0] MODE_CAP_R4    = 4'h6;
  localparam logic [3:0] MODE_CAP_R16   = 4'h7;
  localparam logic [3:0] MODE_CMP_SET   = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR   = 4'h9;
  localparam logic [3:0] MODE_CMP_SW    = 4'ha;
  localparam logic [3:0] MODE_CMP_TRIG  = 4'hb;
  localparam logic [1:0] PWM_CLASS      = 2'h3;

  localparam logic [1:0] STEER_SINGLE   = 2'h0;
  localparam logic [1:0] STEER_FWD      = 2'h1;
  localparam logic [1:0] STEER_HALF     = 2'h2;
  localparam logic [1:0] STEER_REV      = 2'h3;
  localparam logic [1:0] EXT_BUS_12BIT  = 2'h2;

  localparam logic [3:0] PRESCALE_4     = 4'h3;
  localparam logic [3:0] PRESCALE_16    = 4'hf;

endpackage

// >>> edge_capture_if.sv
`timescale 1ns/10ps
// Purpose: Carries capture mode and capture events between modules.
// Assumes: One clock domain.
// Notes:   None.
interface edge_capture_if;
  logic [3:0] mode;
  logic       level;
  logic       event_hit;
  modport ctl (output mode, output level, input event_hit);
  modport det (input mode, input level, output event_hit);
endinterface

// >>> edge_capture.sv
`timescale 1ns/10ps
// Purpose: Detects capture edges with prescaling of rising edges.
// Assumes: Input level already synchronised; mode zero clears state.
// Notes:   One-cycle event pulse.
module edge_capture (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic clk_en,
  edge_capture_if.det cap
);
  import eccp_pkg::*;

  logic       last;
  logic [3:0] count;
  logic       hit;
  logic       next_last;
  logic [3:0] next_count;
  logic       next_hit;

  always_comb begin
    logic rise;
    logic fall;
    rise       = cap.level & ~last;
    fall       = ~cap.level & last;
    next_last  = cap.level;
    next_count = count;
    next_hit   = 1'b0;
    unique case (cap.mode)
      MODE_CAP_FALL: next_hit = fall;
      MODE_CAP_RISE: next_hit = rise;
      MODE_CAP_R4, MODE_CAP_R16: begin
        if (rise) begin
          if ((cap.mode == MODE_CAP_R4) ? (count == PRESCALE_4) : (count == PRESCALE_16)) begin
            next_count = 4'h0;
            next_hit   = 1'b1;
          end else begin
            next_count = count + 4'h1;
          end
        end
      end
      default: next_count = 4'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last  <= 1'b0;
      count <= 4'h0;
      hit   <= 1'b0;
    end else if (clk_en) begin
      last  <= next_last;
      count <= next_count;
      hit   <= next_hit;
    end
  end

  assign cap.event_hit = hit;

endmodule // edge_capture

// >>> eccp_unit.sv
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
// Purpose: Mode control and output steering for one enhanced capture/compare/PWM unit.
// Assumes: Period/duty compare timers are outside; they report matches and pwm level.
// Notes:   Registers over AXI4-Lite; pin outputs are registered.
module eccp_unit #(
  parameter int UNIT_INDEX = 1
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        capture_pin,
  input  wire logic        compare_match,
  input  wire logic        period_match,
  input  wire logic        pwm_raw,
  input  wire logic        adc_enabled,
  output logic             pwm_out_a,
  output logic             pwm_out_b,
  output logic             pwm_out_c,
  output logic             pwm_out_d,
  output logic             own_a,
  output logic             own_b,
  output logic             own_c,
  output logic             own_d,
  output logic             b_c_alternate,
  output logic             a_pin_alt,
  output logic             a_pin_third,
  output logic             plain_override,
  output logic             capture_strobe,
  output logic             timer_reset,
  output logic             adc_start,
  output logic [9:0]       duty_active,
  output logic             match_irq_flag
);
  import eccp_pkg::*;

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [7:0] control, next_control;
  logic [7:0] duty_high_byte, next_duty_high_byte;
  logic [9:0] duty_shadow_q, next_duty_shadow;
  logic       flag, next_flag;
  logic [4:0] config_bits, next_config_bits;
  logic       aw_held, next_aw_held;
  logic       w_held, next_w_held;
  logic [3:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic       bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic       rvalid, next_rvalid;
  logic [1:0] rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic       sync1, sync2, sync3;
  logic       cap_level;

  logic [3:0] op_mode_sel;
  logic [1:0] output_steer_cfg;
  logic [1:0] duty_low_bits;
  logic       unit1_3_pin_select, unit2_pin_select, ext_bus_active, largest_pkg;
  logic [1:0] ext_bus_mode_bits;

  assign op_mode_sel      = control[MODE_MSB:MODE_LSB];
  assign output_steer_cfg = control[STEER_MSB:STEER_LSB];
  assign duty_low_bits    = control[DUTY_MSB:DUTY_LSB];
  // Config word: bit0 unit-one/three select, bit1 unit-two select,
  // bit2 external bus active, bits4:3 bus mode bits.
  assign unit1_3_pin_select = config_bits[0];
  assign unit2_pin_select   = config_bits[1];
  assign ext_bus_active     = config_bits[2];
  assign ext_bus_mode_bits  = config_bits[4:3];
  assign largest_pkg        = 1'b1;

  logic bc_block;
  // external bus blocks B and C
  assign bc_block = (UNIT_INDEX != 2) && ext_bus_active && unit1_3_pin_select &&
                    (ext_bus_mode_bits != EXT_BUS_12BIT);

  function automatic logic is_pwm(input logic [3:0] m);
    return m[3:2] == PWM_CLASS;
  endfunction

  // ****************************************************************
  // Capture path
  // ****************************************************************
  edge_capture_if cap_bus ();
  assign cap_bus.mode  = op_mode_sel;
  assign cap_bus.level = cap_level;

  edge_capture u_edge_capture (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clk_en  (clk_en),
    .cap     (cap_bus.det)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1     <= 1'b0;
      sync2     <= 1'b0;
      sync3     <= 1'b0;
      cap_level <= 1'b0;
    end else if (clk_en) begin
      sync1 <= capture_pin;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3) begin
        cap_level <= sync3;
      end
    end
  end

  // ****************************************************************
  // Bus slave and register updates
  // ****************************************************************
  logic wr_fire, rd_fire, cmp_fire;
  logic [1:0] last_mode_class;
  assign wr_fire = aw_held && w_held && !bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign cmp_fire = compare_match && (op_mode_sel == MODE_CMP_SET ||
                    op_mode_sel == MODE_CMP_CLR || op_mode_sel == MODE_CMP_SW ||
                    op_mode_sel == MODE_CMP_TRIG || op_mode_sel == MODE_CMP_TOG);

  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rresp   = rresp;
    next_rdata   = rdata;
    next_control = control;
    next_duty_high_byte = duty_high_byte;
    next_config_bits    = config_bits;
    next_duty_shadow    = duty_shadow_q;
    next_flag           = flag;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      unique case (aw_addr)
        ADDR_CONTROL:   if (w_strb[0]) next_control = w_data[7:0];
        ADDR_DUTY_HIGH: if (w_strb[0]) next_duty_high_byte = w_data[7:0];
        ADDR_CONFIG:    if (w_strb[0]) next_config_bits = w_data[4:0];
        ADDR_STATUS:    if (w_strb[0] && w_data[0]) next_flag = 1'b0;
        default:        next_bresp = RESP_SLVERR;
      endcase
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (rd_fire) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_CONTROL:   next_rdata = {24'h000000, control};
        ADDR_DUTY_HIGH: next_rdata = {24'h000000, duty_high_byte};
        ADDR_STATUS:    next_rdata = {21'h0, duty_shadow_q, flag};
        ADDR_CONFIG:    next_rdata = {27'h0, config_bits};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (period_match && is_pwm(op_mode_sel)) begin
      next_duty_shadow = {duty_high_byte, duty_low_bits};
    end
    // flag on match except in toggle mode; set wins over clear
    if (cmp_fire && op_mode_sel != MODE_CMP_TOG) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 4'h0;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      rvalid  <= 1'b0;
      rresp   <= RESP_OKAY;
      rdata   <= 32'h00000000;
      control <= CONTROL_RESET;
      duty_high_byte <= 8'h00;
      config_bits    <= CONFIG_RESET;
      duty_shadow_q  <= 10'h000;
      flag           <= 1'b0;
    end else if (clk_en) begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rresp   <= next_rresp;
      rdata   <= next_rdata;
      control <= next_control;
      duty_high_byte <= next_duty_high_byte;
      config_bits    <= next_config_bits;
      duty_shadow_q  <= next_duty_shadow;
      flag           <= next_flag;
    end
  end

  assign s_axi_awready = !aw_held && clk_en;
  assign s_axi_wready  = !w_held && clk_en;
  assign s_axi_arready = !rvalid && clk_en;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rresp   = rresp;
  assign s_axi_rdata   = rdata;

  // ****************************************************************
  // Compare pin and output steering
  // ****************************************************************
  logic       cmp_pin, next_cmp_pin;
  logic [3:0] mode_prev;
  logic [3:0] next_pins, pins;
  logic [3:0] next_own, own;
  logic       next_tr, next_adc, tr_q, adc_q;
  logic       next_alt, next_a_alt, next_a_third, next_plain;
  logic       alt_q, a_alt_q, a_third_q, plain_q, strobe_q;

  always_comb begin
    logic pol_ac, pol_bd;
    next_cmp_pin = cmp_pin;
    next_tr  = 1'b0;
    next_adc = 1'b0;
    pol_ac = op_mode_sel[1];
    pol_bd = op_mode_sel[0];
    if (op_mode_sel == MODE_OFF || op_mode_sel == MODE_RESERVED) begin
      next_cmp_pin = 1'b0;
    end else if (op_mode_sel != mode_prev) begin
      next_cmp_pin = (op_mode_sel == MODE_CMP_CLR);
    end else if (cmp_fire) begin
      unique case (op_mode_sel)
        MODE_CMP_TOG: next_cmp_pin = ~cmp_pin;
        MODE_CMP_SET: next_cmp_pin = 1'b1;
        MODE_CMP_CLR: next_cmp_pin = 1'b0;
        MODE_CMP_TRIG: begin
          next_tr  = (UNIT_INDEX != 3);
          next_adc = (UNIT_INDEX == 2) && adc_enabled;
        end
        default: next_cmp_pin = cmp_pin;
      endcase
    end
    next_pins = 4'h0;
    next_own  = 4'h0;
    if (is_pwm(op_mode_sel)) begin
      unique case (bc_block ? STEER_SINGLE : output_steer_cfg)
        STEER_SINGLE: begin
          next_pins = {3'h0, pwm_raw ^ pol_ac};
          next_own  = 4'h1;
        end
        STEER_FWD: begin
          next_pins = {pwm_raw ^ pol_bd, pol_ac, pol_bd, ~pol_ac};
          next_own  = 4'hf;
        end
        STEER_HALF: begin
          next_pins = {2'h0, ~pwm_raw ^ pol_bd, pwm_raw ^ pol_ac};
          next_own  = 4'h3;
        end
        STEER_REV: begin
          next_pins = {pol_bd, ~pol_ac, pwm_raw ^ pol_bd, pol_ac};
          next_own  = 4'hf;
        end
      endcase
    end else if (op_mode_sel != MODE_OFF && op_mode_sel != MODE_RESERVED) begin
      next_pins = {3'h0, cmp_pin};
      next_own[0] = (op_mode_sel == MODE_CMP_TOG) || (op_mode_sel == MODE_CMP_SET) ||
                    (op_mode_sel == MODE_CMP_CLR);
    end
    next_alt     = (UNIT_INDEX != 2) && !unit1_3_pin_select;
    next_a_alt   = (UNIT_INDEX == 2) && !unit2_pin_select && !(ext_bus_active && largest_pkg);
    next_a_third = (UNIT_INDEX == 2) && !unit2_pin_select && ext_bus_active && largest_pkg;
    next_plain   = (UNIT_INDEX != 2) && next_own[3];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_pin   <= 1'b0;
      mode_prev <= MODE_OFF;
      pins      <= 4'h0;
      own       <= 4'h0;
      tr_q      <= 1'b0;
      adc_q     <= 1'b0;
      alt_q     <= 1'b0;
      a_alt_q   <= 1'b0;
      a_third_q <= 1'b0;
      plain_q   <= 1'b0;
      strobe_q  <= 1'b0;
    end else if (clk_en) begin
      cmp_pin   <= next_cmp_pin;
      mode_prev <= op_mode_sel;
      pins      <= next_pins;
      own       <= next_own;
      tr_q      <= next_tr;
      adc_q     <= next_adc;
      alt_q     <= next_alt;
      a_alt_q   <= next_a_alt;
      a_third_q <= next_a_third;
      plain_q   <= next_plain;
      strobe_q  <= cap_bus.event_hit;
    end
  end

  assign pwm_out_a      = pins[0];
  assign pwm_out_b      = pins[1];
  assign pwm_out_c      = pins[2];
  assign pwm_out_d      = pins[3];
  assign own_a          = own[0];
  assign own_b          = own[1];
  assign own_c          = own[2];
  assign own_d          = own[3];
  assign b_c_alternate  = alt_q;
  assign a_pin_alt      = a_alt_q;
  assign a_pin_third    = a_third_q;
  assign plain_override = plain_q;
  assign capture_strobe = strobe_q;
  assign timer_reset    = tr_q;
  assign adc_start      = adc_q;
  assign duty_active    = duty_shadow_q;
  assign match_irq_flag = flag;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_trigger_unit3: assert property (@(posedge aclk) disable iff (!aresetn)
    (UNIT_INDEX == 3) |-> !timer_reset) else $error("third unit reset timer");
  chk_flag_on_match: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && cmp_fire && op_mode_sel == MODE_CMP_SET) |=> match_irq_flag)
    else $error("flag not set on match");
  chk_single_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && is_pwm(op_mode_sel) && output_steer_cfg == STEER_SINGLE) |=> (own[3:1] == 3'h0))
    else $error("single mode drives b c d");
  chk_off_no_own: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && op_mode_sel == MODE_OFF) |=> (own == 4'h0 && pins == 4'h0))
    else $error("disabled unit drives pins");
  chk_shadow_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && !period_match) |=> $stable(duty_active)) else $error("shadow changed");
  chk_fwd_a_active: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && !bc_block && op_mode_sel == {PWM_CLASS, 2'b00} && output_steer_cfg == STEER_FWD)
    |=> (pwm_out_a && !pwm_out_b && !pwm_out_c)) else $error("forward levels wrong");
  chk_half_c_d_free: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en && is_pwm(op_mode_sel) && output_steer_cfg == STEER_HALF) |=> !own[3] && !own[2])
    else $error("half bridge drives c d");
  chk_quad_override: assert property (@(posedge aclk) disable iff (!aresetn)
    own_d && (UNIT_INDEX != 2) |-> plain_override) else $error("plain pin not overridden");

endmodule // eccp_unit

// >>> bridge_driver_model.sv
`timescale 1ns/10ps
// Purpose: Inputs of the external bridge drivers fed by the four unit pins.
// Assumes: Every driver input has a pull-down.
// Notes:   A pin that the unit does not own reads low.
module bridge_driver_model (
  input  wire logic [3:0] pin,
  input  wire logic [3:0] own,
  output logic      [3:0] leg
);
  assign leg = pin & own;
endmodule // bridge_driver_model

// >>> enhanced_ccp_mode_and_output_steering_tb.sv
`timescale 1ns/10ps
// Purpose: Self-checking bench for the enhanced unit mode and steering block.
// Assumes: Unit one, clock enable high, full write strobes.
// Notes:   Expected values come from the local tables and model.
module enhanced_ccp_mode_and_output_steering_tb;
  import eccp_pkg::*;
  logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, capture_pin = 0, compare_match = 0;
  logic        period_match = 0, pwm_raw = 0, b0, ia, ib, m;
  logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, eo, el;
  logic [1:0]  br, rr;
  logic [31:0] s_axi_wdata = 0, rd;
  logic [7:0]  h;
  logic [8:0]  e;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         b_c_alternate, plain_override, capture_strobe, timer_reset, adc_start;
  wire         match_irq_flag, a_pin_alt, a_pin_third;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [9:0]   duty_active;
  wire [3:0]   pin, own, leg;
  int          err_count = 0, tests_run = 0, cyc = 0, nstr = 0, ntr = 0, nadc = 0, n0, n1;
  int          seed = 32'h5d267d7e;
  // Compare table: mode, own_a, pin before, pin after, flag, trigger.
  logic [8:0]  cm [7] = '{9'b1000_1_0_1_1_0, 9'b1001_1_1_0_1_0, 9'b0010_1_x_x_x_0,
                          9'b1010_0_x_x_1_0, 9'b1011_x_x_x_1_1, 9'b0001_0_x_x_0_0,
                          9'b0000_0_x_x_0_0};
  logic [15:0] cp [4] = '{16'h1004, 16'h1005, 16'h0406, 16'h0107};
  logic [6:0]  cf [4] = '{{5'h07, 2'b00}, {5'h17, 2'b10}, {5'h06, 2'b11}, {5'h03, 2'b10}};

  eccp_unit #(.UNIT_INDEX(1)) uut (
    .aclk, .aresetn, .clk_en(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .capture_pin,
    .compare_match, .period_match, .pwm_raw, .adc_enabled(1'b1),
    .pwm_out_a(pin[3]), .pwm_out_b(pin[2]), .pwm_out_c(pin[1]), .pwm_out_d(pin[0]),
    .own_a(own[3]), .own_b(own[2]), .own_c(own[1]), .own_d(own[0]), .b_c_alternate,
    .a_pin_alt, .a_pin_third, .plain_override, .capture_strobe, .timer_reset,
    .adc_start, .duty_active, .match_irq_flag);
  bridge_driver_model drv (.pin(pin), .own(own), .leg(leg));

  initial forever #2.5 aclk = ~aclk;

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (capture_strobe === 1'b1) nstr <= nstr + 1;
    if (timer_reset === 1'b1) ntr <= ntr + 1;
    if (adc_start === 1'b1) nadc <= nadc + 1;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bit aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    br = s_axi_bresp;
    s_axi_bready <= 0;
    @(posedge aclk);
  endtask

  task automatic rdr(input logic [3:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge aclk);
  endtask

  task automatic pulse(input bit p);
    if (p) period_match <= 1;
    else compare_match <= 1;
    @(posedge aclk);
    period_match <= 0;
    compare_match <= 0;
    tick(3);
  endtask

  initial begin
    tick(10);
    aresetn <= 1;
    rdr(ADDR_CONTROL);
    chk("control", 32'h0, rd);
    chk("rresp", RESP_OKAY, rr);
    rdr(ADDR_CONFIG);
    chk("config", 32'h3, rd);
    // ************************************************
    // Steering and polarity
    // ************************************************
    for (int s = 0; s < 4; s++) begin
      for (int p = 0; p < 4; p++) begin
        pwm_raw <= 1'($random(seed));
        wr(ADDR_CONTROL, {s[1:0], 2'b00, 2'b11, p[1:0]});
        tick(3);
        ia = p[1];
        ib = p[0];
        m = pwm_raw;
        case (s)
          0: {eo, el} = {4'b1000, m ^ ia, 3'b0};
          1: {eo, el} = {4'b1111, !ia, ib, ia, m ^ ib};
          2: {eo, el} = {4'b1100, m ^ ia, !m ^ ib, 2'b0};
          default: {eo, el} = {4'b1111, ia, m ^ ib, !ia, ib};
        endcase
        chk("own", eo, own);
        chk("legs", el, leg);
        chk("quad", s[0], plain_override);
      end
    end
    wr(ADDR_CONTROL, 32'h4c);
    foreach (cf[i]) begin
      wr(ADDR_CONFIG, cf[i][6:2]);
      tick(2);
      chk("own_b", cf[i][1], own[2]);
      chk("alt", cf[i][0], b_c_alternate);
      chk("a_pin", 32'h0, {a_pin_alt, a_pin_third});
    end
    h = 8'($random(seed));
    wr(ADDR_DUTY_HIGH, h);
    chk("bresp", RESP_OKAY, br);
    wr(ADDR_CONTROL, 32'h2c);
    chk("duty_hold", 32'h0, duty_active);
    pulse(1);
    chk("duty", {h, 2'b10}, duty_active);
    rdr(ADDR_STATUS);
    chk("status", {h, 2'b10}, rd[10:1]);
    // ************************************************
    // Compare modes
    // ************************************************
    foreach (cm[i]) begin
      e = cm[i];
      wr(ADDR_CONTROL, {4'h4, e[8:5]});
      wr(ADDR_STATUS, 32'h1);
      tick(2);
      b0 = pin[3];
      n0 = ntr;
      n1 = nadc;
      if (e[3] !== 1'bx) chk("pin_init", e[3], pin[3]);
      pulse(0);
      if (e[8:5] == 4'h2) e[2] = !b0;
      if (e[4] !== 1'bx) chk("own_a", e[4], own[3]);
      chk("own_bcd", 32'h0, own[2:0]);
      if (e[2] !== 1'bx) chk("pin_match", e[2], pin[3]);
      if (e[1] !== 1'bx) chk("flag", e[1], match_irq_flag);
      chk("trig", e[0], ntr - n0);
      chk("adc", 32'h0, nadc - n1);
    end
    // ************************************************
    // Capture edges
    // ************************************************
    foreach (cp[i]) begin
      wr(ADDR_CONTROL, 32'h0);
      wr(ADDR_CONTROL, cp[i][7:0]);
      n0 = nstr;
      repeat (32) begin
        capture_pin <= !capture_pin;
        tick(6);
      end
      tick(4);
      chk("captures", cp[i][15:8], nstr - n0);
    end
    wrap_up();
  end
endmodule // enhanced_ccp_mode_and_output_steering_tb
